// ===== verilog/aof_pkg.sv
// Function
// - Each host write to the sample port pushes its data into the FIFO; a write while full is dropped.
// - The FIFO shows empty, half-full and full in a separate status word.
// - Each pushed sample is kept as an unsigned straight-binary code.
// - In two-sample mode a write queues the upper half, then the lower.
// - In one-sample mode the port is 16 bits and a write queues one sample.
// - The 4-bit select field names, by binary index, the channel written.
// - A 1 in the ground-all bit grounds every reference, whatever the select.
// - The reference bit picks the internal reference at 0, connector at 1.
// - The deglitch bit turns the chosen channel's deglitch circuit on or off.
// - The polarity bit makes the chosen channel bipolar at 1, unipolar at 0.
package aof_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_SAMPLE_PORT = 8'h14;
    localparam logic [7:0] IDX_CHAN_CFG    = 8'h16;
    localparam logic [7:0] IDX_FIFO_STAT   = 8'h20;
    localparam logic [7:0] IDX_IRQ_STAT    = 8'h21;
    localparam logic [7:0] IDX_IRQ_MASK    = 8'h22;
    localparam logic [7:0] IDX_CHAN_READ   = 8'h23;
    localparam int         ADDR_W          = 8;
    localparam int         DATA_W          = 32;
    localparam int         SAMPLE_W        = 16;

    ////////////////////////////////////////////////////////////////////////
    // configuration word fields
    localparam int CFG_SEL_LSB = 8;
    localparam int CFG_SEL_W   = 4;
    localparam int CFG_GND_BIT = 3;
    localparam int CFG_REF_BIT = 2;
    localparam int CFG_DEG_BIT = 1;
    localparam int CFG_POL_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // status and interrupt fields
    localparam int IRQ_W          = 3;
    localparam int IRQ_OVERFLOW   = 0;
    localparam int IRQ_EMPTY      = 1;
    localparam int IRQ_BELOW_HALF = 2;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [IRQ_W-1:0]     IRQ_MASK_RST = 3'h0;
    localparam logic [IRQ_W-1:0]     IRQ_STAT_RST = 3'h0;
    localparam logic [CFG_SEL_W-1:0] SEL_RST      = 4'h0;
    localparam logic                 GND_RST      = 1'b0;
    localparam logic [DATA_W-1:0]    RDATA_RST    = 32'h0000_0000;

    typedef struct packed {
        logic refExternal;
        logic deglitchEn;
        logic bipolar;
    } aof_chan_cfg_t;

    localparam aof_chan_cfg_t CHAN_CFG_RST = 3'h0;

    typedef struct packed {
        logic full;
        logic halfFull;
        logic empty;
    } aof_fifo_flags_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } aof_bus_req_t;

    function automatic logic [ADDR_W-1:0] idx2addr(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction

endpackage

// ===== verilog/aof_sample_mem.sv
`timescale 1ns/1ps
module aof_sample_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             wrEn,
    input  wire logic             wrPair,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrDataA,
    input  wire logic [WIDTH-1:0] wrDataB,
    input  wire logic             rdEn,
    input  wire logic [AW-1:0]    rdAddr,
    output logic      [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    pairAddr;
    logic [WIDTH-1:0] peek;

    assign pairAddr = wrAddr + AW'(1);
    assign peek     = mem[rdAddr];

    ////////////////////////////////////////////////////////////////////////
    // second sample follows
    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrAddr] <= wrDataA;
            if (wrPair) begin
                mem[pairAddr] <= wrDataB;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdData <= '0;
        end else if (rdEn) begin
            rdData <= peek;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_pairOrder;
        @(posedge clk_sys) disable iff (rst)
        wrEn && wrPair |=> mem[$past(pairAddr)] == $past(wrDataB)
            && mem[$past(wrAddr)] == $past(wrDataA);
    endproperty
    a_pairOrder: assert property (p_pairOrder)
        else $error("paired write did not land in order");

    property p_rawRead;
        @(posedge clk_sys) disable iff (rst)
        rdEn |=> rdData == $past(peek);
    endproperty
    a_rawRead: assert property (p_rawRead)
        else $error("sample altered on read");

endmodule

// ===== verilog/aof_regs.sv
`timescale 1ns/1ps
module aof_regs #(
    parameter int   NUM_CH      = 8,
    parameter int   DEPTH       = 64,
    parameter logic TWO_SAMPLES = 1'b1
) (
    input  wire logic                                  clk_sys,
    input  wire logic                                  rst,
    input  wire aof_pkg::aof_bus_req_t                 busReq,
    output logic            [aof_pkg::DATA_W-1:0]      busRdData,
    input  wire logic                                  popReq,
    output logic            [aof_pkg::SAMPLE_W-1:0]    sampleData,
    output logic                                       sampleValid,
    output aof_pkg::aof_fifo_flags_t                   fifoFlags,
    output aof_pkg::aof_chan_cfg_t [NUM_CH-1:0]        chanCfg,
    output logic                                       referenceGroundAll,
    output logic                                       irq
);
    import aof_pkg::*;

    localparam int          AW     = $clog2(DEPTH);
    localparam int          CW     = AW + 1;
    localparam logic [CW-1:0] PUSH_N = TWO_SAMPLES ? CW'(2) : CW'(1);
    localparam logic [CW-1:0] FULL_AT = CW'(DEPTH) - PUSH_N;
    localparam logic [CW-1:0] HALF_AT = CW'(DEPTH / 2);

    localparam logic [ADDR_W-1:0] A_SAMPLE = idx2addr(IDX_SAMPLE_PORT);
    localparam logic [ADDR_W-1:0] A_CFG    = idx2addr(IDX_CHAN_CFG);
    localparam logic [ADDR_W-1:0] A_FSTAT  = idx2addr(IDX_FIFO_STAT);
    localparam logic [ADDR_W-1:0] A_ISTAT  = idx2addr(IDX_IRQ_STAT);
    localparam logic [ADDR_W-1:0] A_IMASK  = idx2addr(IDX_IRQ_MASK);
    localparam logic [ADDR_W-1:0] A_CREAD  = idx2addr(IDX_CHAN_READ);

    ////////////////////////////////////////////////////////////////////////
    // decode
    logic                  wrSample;
    logic                  wrCfg;
    logic                  accept;
    logic                  overflow;
    logic                  pop;
    logic [CFG_SEL_W-1:0]  cfgSel;
    logic                  gndBit;
    logic                  refBit;
    logic                  degBit;
    logic                  polBit;
    logic                  selValid;
    logic [SAMPLE_W-1:0]   firstSample;
    logic [SAMPLE_W-1:0]   secondSample;

    assign wrSample = busReq.wr && (busReq.addr == A_SAMPLE);
    assign wrCfg    = busReq.wr && (busReq.addr == A_CFG);
    assign cfgSel   = busReq.wdata[CFG_SEL_LSB +: CFG_SEL_W];
    assign gndBit   = busReq.wdata[CFG_GND_BIT];
    assign refBit   = busReq.wdata[CFG_REF_BIT];
    assign degBit   = busReq.wdata[CFG_DEG_BIT];
    assign polBit   = busReq.wdata[CFG_POL_BIT];
    assign selValid = 32'(cfgSel) < NUM_CH;

    assign firstSample  = TWO_SAMPLES ? busReq.wdata[31:16]
                                      : busReq.wdata[15:0];
    assign secondSample = busReq.wdata[15:0];

    ////////////////////////////////////////////////////////////////////////
    // fifo pointers and level
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic [AW-1:0] next_wrPtr;
    logic [AW-1:0] next_rdPtr;
    logic [CW-1:0] next_count;
    logic          next_sampleValid;

    // full means no room for a whole write, so a pair never splits
    // fifo flags
    always_comb begin
        fifoFlags.empty    = (count == '0);
        fifoFlags.halfFull = (count >= HALF_AT);
        fifoFlags.full     = (count > FULL_AT);
    end

    assign accept   = wrSample && !fifoFlags.full;
    assign overflow = wrSample && fifoFlags.full;
    assign pop      = popReq && !fifoFlags.empty;

    always_comb begin
        next_wrPtr       = accept ? wrPtr + AW'(PUSH_N) : wrPtr;
        next_rdPtr       = pop ? rdPtr + AW'(1) : rdPtr;
        next_count       = count;
        if (accept) begin
            next_count = next_count + PUSH_N;
        end
        if (pop) begin
            next_count = next_count - CW'(1);
        end
        next_sampleValid = pop;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrPtr       <= '0;
            rdPtr       <= '0;
            count       <= '0;
            sampleValid <= 1'b0;
        end else begin
            wrPtr       <= next_wrPtr;
            rdPtr       <= next_rdPtr;
            count       <= next_count;
            sampleValid <= next_sampleValid;
        end
    end

    aof_sample_mem #(
        .WIDTH (SAMPLE_W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wrEn    (accept),
        .wrPair  (TWO_SAMPLES),
        .wrAddr  (wrPtr),
        .wrDataA (firstSample),
        .wrDataB (secondSample),
        .rdEn    (pop),
        .rdAddr  (rdPtr),
        .rdData  (sampleData)
    );

    ////////////////////////////////////////////////////////////////////////
    // channel settings, one stored set per channel
    aof_chan_cfg_t [NUM_CH-1:0] next_chanCfg;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
        always_comb begin
            next_chanCfg[i] = chanCfg[i];
            if (wrCfg && (32'(cfgSel) == i)) begin
                next_chanCfg[i].refExternal = refBit;
                next_chanCfg[i].deglitchEn  = degBit;
                next_chanCfg[i].bipolar     = polBit;
            end
        end

        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                chanCfg[i] <= CHAN_CFG_RST;
            end else begin
                chanCfg[i] <= next_chanCfg[i];
            end
        end

        property p_otherKept;
            @(posedge clk_sys) disable iff (rst)
            wrCfg && (32'(cfgSel) != i) |=> $stable(chanCfg[i]);
        endproperty
        a_otherKept: assert property (p_otherKept)
            else $error("unselected channel changed");
    end

    // ground-all holds until a later write clears it
    logic                 next_ground;
    logic [CFG_SEL_W-1:0] lastSel;
    logic [CFG_SEL_W-1:0] next_lastSel;

    always_comb begin
        next_ground  = wrCfg ? gndBit : referenceGroundAll;
        next_lastSel = wrCfg ? cfgSel : lastSel;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            referenceGroundAll <= GND_RST;
            lastSel            <= SEL_RST;
        end else begin
            referenceGroundAll <= next_ground;
            lastSel            <= next_lastSel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: set wins over a write-one clear in the same cycle
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic [IRQ_W-1:0] next_irqStat;
    logic [IRQ_W-1:0] next_irqMask;
    logic [IRQ_W-1:0] irqEvent;
    logic [IRQ_W-1:0] irqClear;

    always_comb begin
        irqEvent                 = '0;
        irqEvent[IRQ_OVERFLOW]   = overflow;
        irqEvent[IRQ_EMPTY]      = !fifoFlags.empty && (next_count == '0);
        irqEvent[IRQ_BELOW_HALF] = fifoFlags.halfFull
                                   && (next_count < HALF_AT);
        irqClear = '0;
        if (busReq.wr && (busReq.addr == A_ISTAT)) begin
            irqClear = busReq.wdata[IRQ_W-1:0];
        end
        next_irqStat = (irqStat & ~irqClear) | irqEvent;
        next_irqMask = irqMask;
        if (busReq.wr && (busReq.addr == A_IMASK)) begin
            next_irqMask = busReq.wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irqStat <= IRQ_STAT_RST;
            irqMask <= IRQ_MASK_RST;
        end else begin
            irqStat <= next_irqStat;
            irqMask <= next_irqMask;
        end
    end

    assign irq = |(irqStat & irqMask);

    ////////////////////////////////////////////////////////////////////////
    // read path: data stand only in the cycle after the strobe
    logic [DATA_W-1:0] next_busRdData;
    aof_chan_cfg_t     shownCfg;

    assign shownCfg = (32'(lastSel) < NUM_CH) ? chanCfg[lastSel]
                                              : CHAN_CFG_RST;

    always_comb begin
        next_busRdData = RDATA_RST;
        if (busReq.rd) begin
            unique case (busReq.addr)
                A_FSTAT: begin
                    next_busRdData[2:0] = fifoFlags;
                end
                A_ISTAT: begin
                    next_busRdData[IRQ_W-1:0] = irqStat;
                end
                A_IMASK: begin
                    next_busRdData[IRQ_W-1:0] = irqMask;
                end
                A_CREAD: begin
                    next_busRdData[CFG_SEL_LSB +: CFG_SEL_W] = lastSel;
                    next_busRdData[CFG_GND_BIT] = referenceGroundAll;
                    next_busRdData[CFG_REF_BIT] = shownCfg.refExternal;
                    next_busRdData[CFG_DEG_BIT] = shownCfg.deglitchEn;
                    next_busRdData[CFG_POL_BIT] = shownCfg.bipolar;
                end
                default: begin
                    next_busRdData = RDATA_RST;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busRdData <= RDATA_RST;
        end else begin
            busRdData <= next_busRdData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_sampleWrite;
        accept && !pop;
    endsequence
    sequence s_cfgWrite;
        wrCfg && selValid;
    endsequence

    property p_pushCount;
        s_sampleWrite |=> count == $past(count) + PUSH_N;
    endproperty
    a_pushCount: assert property (p_pushCount)
        else $error("accepted write did not raise fifo level");
    property p_statusRead;
        busReq.rd && (busReq.addr == A_FSTAT)
            |=> busRdData[2:0] == $past(fifoFlags);
    endproperty
    a_statusRead: assert property (p_statusRead)
        else $error("fifo status read wrong");
    property p_pairPush;
        TWO_SAMPLES && accept |=> wrPtr == $past(wrPtr) + AW'(2);
    endproperty
    a_pairPush: assert property (p_pairPush)
        else $error("two-sample write did not queue two");
    property p_singlePush;
        (s_sampleWrite and !TWO_SAMPLES) |=> count == $past(count) + CW'(1);
    endproperty
    a_singlePush: assert property (p_singlePush)
        else $error("one-sample write did not queue one");
    property p_selTarget;
        s_cfgWrite |=> chanCfg[$past(cfgSel)]
            == {$past(refBit), $past(degBit), $past(polBit)};
    endproperty
    a_selTarget: assert property (p_selTarget)
        else $error("selected channel not loaded");
    property p_groundAll;
        wrCfg && gndBit |=> referenceGroundAll ##1
            (referenceGroundAll || $past(wrCfg));
    endproperty
    a_groundAll: assert property (p_groundAll)
        else $error("ground-all not applied");
    property p_refSource;
        s_cfgWrite |=> chanCfg[$past(cfgSel)].refExternal == $past(refBit);
    endproperty
    a_refSource: assert property (p_refSource)
        else $error("reference source not stored");
    property p_deglitch;
        s_cfgWrite |=> chanCfg[$past(cfgSel)].deglitchEn == $past(degBit);
    endproperty
    a_deglitch: assert property (p_deglitch)
        else $error("deglitch enable not stored");
    property p_polarity;
        s_cfgWrite |=> chanCfg[$past(cfgSel)].bipolar == $past(polBit);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("polarity not stored");
    property p_fullDrop;
        overflow && !pop |=> count == $past(count);
    endproperty
    a_fullDrop: assert property (p_fullDrop)
        else $error("write while full changed level");
endmodule

// ===== verif/aof_host_model.sv
`timescale 1ns/1ps
module aof_host_model (
    input  wire logic            clk_sys,
    input  wire logic            fifoFull,
    output aof_pkg::aof_bus_req_t busReq
);
    import aof_pkg::*;

    initial busReq = '0;

    ////////////////////////////////////////////////////////////////////////
    // one strobe cycle, then a released bus shows inverted address and data
    // so a design that samples outside the strobe picks up garbage
    task automatic xfer(input logic [7:0] a, input logic [31:0] d,
                        input logic w);
        @(posedge clk_sys);
        busReq <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk_sys);
        busReq <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    ////////////////////////////////////////////////////////////////////////
    // hold off while full
    task automatic push(input logic [31:0] d, input logic ignoreFull);
        int n;
        n = 0;
        // look off the edge so the last write's level is already visible
        #1;
        while (fifoFull === 1'b1 && !ignoreFull && n < 500) begin
            @(negedge clk_sys);
            n++;
        end
        xfer(8'h50, d, 1'b1);
    endtask
endmodule

// ===== verif/aof_regs_bench.sv
`timescale 1ns/1ps
module aof_regs_bench;
    import aof_pkg::*;

    localparam int         NCH   = 8;
    localparam int         DEP   = 8;
    localparam logic [7:0] A_SMP = 8'h50;
    localparam logic [7:0] A_CFG = 8'h58;
    localparam logic [7:0] A_FST = 8'h80;
    localparam logic [7:0] A_IST = 8'h84;
    localparam logic [7:0] A_IMK = 8'h88;
    localparam logic [7:0] A_CRB = 8'h8c;

    logic                    clk_sys;
    logic                    rst;
    logic                    popReq;
    logic                    popEn;
    logic                    rdSeen;
    aof_bus_req_t            busReq;
    logic [31:0]             busRdData;
    logic [15:0]             sampleData;
    logic                    sampleValid;
    aof_fifo_flags_t         fifoFlags;
    aof_chan_cfg_t [NCH-1:0] chanCfg;
    aof_chan_cfg_t [NCH-1:0] cfgModel;
    logic                    referenceGroundAll;
    logic                    irq;
    logic [31:0]             rq[$];
    logic [15:0]             sq[$];
    logic [15:0]             narrowData;
    logic                    narrowValid;
    aof_fifo_flags_t         narrowFlags;
    logic [15:0]             nq[$];
    int                      n_errors;
    int                      n_checks;

    aof_regs #(.NUM_CH(NCH), .DEPTH(DEP), .TWO_SAMPLES(1'b1)) i_dut (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .busReq             (busReq),
        .busRdData          (busRdData),
        .popReq             (popReq),
        .sampleData         (sampleData),
        .sampleValid        (sampleValid),
        .fifoFlags          (fifoFlags),
        .chanCfg            (chanCfg),
        .referenceGroundAll (referenceGroundAll),
        .irq                (irq)
    );

    // one-sample variant shares the bus and the drain requests
    aof_regs #(.NUM_CH(NCH), .DEPTH(DEP), .TWO_SAMPLES(1'b0)) i_dut_narrow (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .busReq             (busReq),
        .busRdData          (),
        .popReq             (popReq),
        .sampleData         (narrowData),
        .sampleValid        (narrowValid),
        .fifoFlags          (narrowFlags),
        .chanCfg            (),
        .referenceGroundAll (),
        .irq                ()
    );

    aof_host_model i_host (
        .clk_sys  (clk_sys),
        .fifoFull (fifoFlags.full),
        .busReq   (busReq)
    );

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(a, d, 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        i_host.xfer(a, 32'h0000_0000, 1'b0);
    endtask

    task automatic cfg(input logic [3:0] sel, input logic g,
                       input logic [2:0] b);
        logic [2:0] rb;
        wr(A_CFG, {20'h0_0000, sel, 4'h0, g, b});
        rb = 3'h0;
        if (sel < NCH) begin
            cfgModel[sel] = b;
            rb = b;
        end
        #1;
        chk({8'h00, chanCfg}, {8'h00, cfgModel}, "chan cfg");
        chk({31'h0, referenceGroundAll}, {31'h0, g}, "ground");
        rd(A_CRB, {20'h0_0000, sel, 4'h0, g, rb});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watcher: read data and popped samples against the oldest note
    always @(posedge clk_sys) begin
        if (rdSeen === 1'b1) begin
            if (rq.size() == 0) begin
                chk(32'h1, 32'h0, "read without note");
            end else begin
                chk(busRdData, rq.pop_front(), "read data");
            end
        end else if (rst === 1'b0) begin
            chk(busRdData, 32'h0000_0000, "idle read data");
        end
        if (sampleValid === 1'b1) begin
            if (sq.size() == 0) begin
                chk(32'h1, 32'h0, "sample without note");
            end else begin
                chk(32'(sampleData), 32'(sq.pop_front()), "smp");
            end
        end
        if (narrowValid === 1'b1) begin
            if (nq.size() == 0) begin
                chk(32'h1, 32'h0, "narrow sample without note");
            end else begin
                chk(32'(narrowData), 32'(nq.pop_front()), "narrow");
            end
        end
        rdSeen <= busReq.rd;
    end

    // drain side stalls at random while enabled
    always @(posedge clk_sys) begin
        popReq <= popEn && ($urandom % 3 != 0);
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        int          n;
        rst      = 1'b1;
        popReq   = 1'b0;
        popEn    = 1'b0;
        rdSeen   = 1'b0;
        cfgModel = '0;
        n_errors = 0;
        n_checks = 0;
        void'($urandom(32'h1c52_3608));
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk({29'h0, fifoFlags}, 32'h1, "reset flags");
        chk({8'h00, chanCfg}, 32'h0, "reset chan cfg");
        chk({30'h0, irq, referenceGroundAll}, 32'h0, "reset irq gnd");
        rd(A_SMP, 32'h0000_0000);
        rd(8'hfc, 32'h0000_0000);
        wr(8'hf0, 32'hffff_ffff);
        // per-channel settings, every channel twice with random bits
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < NCH; c++) begin
                cfg(c[3:0], 1'($urandom % 2), 3'($urandom % 8));
            end
        end
        cfg(4'h3, 1'b0, 3'h7);
        cfg(4'hf, 1'b1, 3'h5);
        cfg(4'h8, 1'b0, 3'h2);
        cfg(4'h3, 1'b0, 3'h0);
        // fill the sample queue to full, upper half first
        rd(A_FST, 32'h0000_0001);
        wr(A_IST, 32'h0000_0007);
        for (int i = 0; i < DEP / 2; i++) begin
            d = $urandom;
            sq.push_back(d[31:16]);
            sq.push_back(d[15:0]);
            nq.push_back(d[15:0]);
            i_host.push(d, 1'b0);
            if (i == 0) begin
                rd(A_FST, 32'h0000_0000);
            end
        end
        rd(A_FST, 32'h0000_0006);
        // a write while full is dropped and flagged
        d = $urandom;
        nq.push_back(d[15:0]);
        i_host.push(d, 1'b1);
        rd(A_FST, 32'h0000_0006);
        rd(A_IST, 32'h0000_0001);
        wr(A_IMK, 32'h0000_0001);
        #1;
        chk({31'h0, irq}, 32'h1, "irq raised");
        chk({29'h0, narrowFlags}, 32'h2, "narrow flags");
        wr(A_IST, 32'h0000_0001);
        #1;
        chk({31'h0, irq}, 32'h0, "irq cleared");
        // drain with stalls; codes come back unaltered
        popEn = 1'b1;
        n = 0;
        while (sq.size() != 0 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        popEn = 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(sq.size(), 32'h0, "samples left");
        chk(nq.size(), 32'h0, "narrow left");
        rd(A_FST, 32'h0000_0001);
        rd(A_IST, 32'h0000_0006);
        #1;
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(A_IMK, 32'h0000_0006);
        #1;
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        rd(A_IMK, 32'h0000_0006);
        wr(A_IST, 32'h0000_0006);
        #1;
        chk({31'h0, irq}, 32'h0, "irq cleared");
        repeat (3) @(posedge clk_sys);
        chk(rq.size(), 32'h0, "reads left");
        end_sim();
    end
endmodule
